// [pvat_pkg.sv]
// Package with constants and carrier types for the remote window translator
package pvat_pkg;
   localparam int unsigned ENTRY_COUNT = 8192;
   localparam int unsigned INDEX_WIDTH = 13;
   localparam int unsigned PAGE_BYTES = 4096;
   localparam int unsigned PAGE_SHIFT = 12;
   localparam int unsigned WIN_SHIFT = 25;
   localparam int unsigned MAP_SHIFT = 16;
   localparam logic [31:0] MAP_ENTRY_FIRST = 32'h0000_0000;
   localparam logic [31:0] MAP_ENTRY_LAST = 32'h0000_7FFF;
   localparam int unsigned BIT_INVALID = 0;
   localparam int unsigned BIT_SWAP_WIDE = 1;
   localparam int unsigned BIT_SWAP_WORD = 2;
   localparam int unsigned BIT_SWAP_BYTE = 3;
   localparam int unsigned DEST_LSB = 4;
   localparam int unsigned AM_LSB = 6;
   localparam int unsigned RADDR_LSB = 12;
   localparam logic [5:0] AM_A16_SUP = 6'h2D;
   localparam logic [5:0] AM_A16_USR = 6'h29;
   localparam logic [5:0] AM_A16_LCK = 6'h2C;

   typedef enum logic [1:0] {
      PVAT_DEST_RSVD = 2'b00,
      PVAT_DEST_IO = 2'b01,
      PVAT_DEST_RAM = 2'b10,
      PVAT_DEST_DPR = 2'b11
   } pvat_dest_type;

   typedef enum logic [1:0] {
      PVAT_SZ_BYTE = 2'b00,
      PVAT_SZ_WORD = 2'b01,
      PVAT_SZ_LONG = 2'b10
   } pvat_size_type;

   typedef struct packed {
      logic [31:0] addr;
      logic write;
      pvat_size_type size;
      logic [31:0] wdata;
   } pvat_req_type;

   typedef struct packed {
      logic [31:0] addr;
      logic [5:0] am;
      pvat_dest_type dest;
      logic swap_wide;
      logic swap_word;
      logic swap_byte;
      logic write;
      pvat_size_type size;
      logic [31:0] wdata;
   } pvat_rem_type;
endpackage

// [pvat_entry_table.sv]
// Flip-flop store of the page translation entries, one write and one read port
`timescale 1ns/1ps
`default_nettype none
module pvat_entry_table (
   input wire logic i_ref_clk,
   input wire logic i_wr_en,
   input wire logic [12:0] i_wr_index,
   input wire logic [1:0] i_wr_half,
   input wire logic [31:0] i_wr_data,
   input wire logic [12:0] i_rd_index,
   output logic [31:0] o_rd_data
);
   logic [31:0] mem_reg [pvat_pkg::ENTRY_COUNT];
   logic [31:0] rd_reg;
   logic [31:0] rd_next;

   // No reset: entry contents are undefined until software fills them
   always_comb begin
      rd_next = mem_reg[i_rd_index];
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_wr_en && i_wr_half[0]) begin
         mem_reg[i_wr_index][15:0] <= i_wr_data[15:0];
      end
      if (i_wr_en && i_wr_half[1]) begin
         mem_reg[i_wr_index][31:16] <= i_wr_data[31:16];
      end
      rd_reg <= rd_next;
   end

   assign o_rd_data = rd_reg;
endmodule
`default_nettype wire

// [pvat_dpr_arbiter.sv]
// Round-robin arbiter for the shared dual port RAM, grant held while requested
`timescale 1ns/1ps
`default_nettype none
module pvat_dpr_arbiter (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic [1:0] i_req,
   output logic [1:0] o_gnt
);
   logic [1:0] gnt_reg;
   logic [1:0] gnt_next;
   logic last_reg;
   logic last_next;

   always_comb begin
      gnt_next = gnt_reg;
      last_next = last_reg;
      if ((gnt_reg & i_req) == 2'b00) begin
         gnt_next = 2'b00;
         if (i_req == 2'b11) begin
            gnt_next = last_reg ? 2'b01 : 2'b10;
         end else begin
            gnt_next = i_req;
         end
         if (gnt_next != 2'b00) begin
            last_next = gnt_next[1];
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         gnt_reg <= 2'b00;
         last_reg <= 1'b0;
      end else begin
         gnt_reg <= gnt_next;
         last_reg <= last_next;
      end
   end

   assign o_gnt = gnt_reg;
endmodule
`default_nettype wire

// [pvat_translator.sv]
// Remote window translator: entry table access and address/attribute translation
`timescale 1ns/1ps
`default_nettype none
module pvat_translator (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic [31:0] i_win_base,
   input wire logic [31:0] i_map_base,
   input wire logic i_req_valid,
   output logic o_req_ready,
   input wire pvat_pkg::pvat_req_type i_req,
   output logic o_rsp_valid,
   output logic [31:0] o_rsp_rdata,
   output logic o_page_invalid,
   output logic o_rem_valid,
   input wire logic i_rem_ready,
   output pvat_pkg::pvat_rem_type o_rem,
   input wire logic i_rem_rsp_valid,
   input wire logic [31:0] i_rem_rsp_rdata,
   input wire logic i_far_dpr_req,
   output logic o_far_dpr_gnt
);
   typedef enum logic [1:0] {
      PVAT_ST_IDLE = 2'b00,
      PVAT_ST_LOOK = 2'b01,
      PVAT_ST_SEND = 2'b10,
      PVAT_ST_WAIT = 2'b11
   } pvat_state_type;

   pvat_state_type state_reg;
   pvat_state_type state_next;
   pvat_pkg::pvat_req_type req_reg;
   pvat_pkg::pvat_req_type req_next;
   logic kind_map_reg;
   logic kind_map_next;
   logic map_low_reg;
   logic map_low_next;
   pvat_pkg::pvat_rem_type rem_reg;
   pvat_pkg::pvat_rem_type rem_next;
   logic [31:0] rsp_data_reg;
   logic [31:0] rsp_data_next;
   logic rsp_valid_reg;
   logic rsp_valid_next;
   logic invalid_reg;
   logic invalid_next;

   logic [31:0] win_off;
   logic [31:0] map_off;
   logic win_hit;
   logic map_hit;
   logic map_entry_hit;
   logic take;
   logic [12:0] rd_index;
   // Index of the last taken lookup, window page or mapping register, kept only for the index check
   logic [12:0] look_index_reg;
   logic [12:0] look_index_next;
   logic tbl_wr_en;
   logic [1:0] tbl_wr_half;
   logic [31:0] entry;
   logic [1:0] dpr_gnt;
   logic local_dpr_req;
   logic send_ok;
   pvat_pkg::pvat_rem_type xl;

   // Byte lane swap shared by outbound write data and returned read data
   function automatic logic [31:0] swap_lanes(input pvat_pkg::pvat_size_type sz, input logic wide,
                                              input logic word, input logic byt, input logic [31:0] d);
      logic [31:0] r;
      r = d;
      if (sz == pvat_pkg::PVAT_SZ_LONG) begin
         if (wide) begin
            r = {d[7:0], d[15:8], d[23:16], d[31:24]};
         end
      end else if (sz == pvat_pkg::PVAT_SZ_WORD) begin
         if (wide) begin
            r = {r[23:16], r[31:24], r[7:0], r[15:8]};
         end
         if (word) begin
            r = {r[15:0], r[31:16]};
         end
      end else if (byt) begin
         r = {d[23:16], d[31:24], d[7:0], d[15:8]};
      end
      return r;
   endfunction

   assign win_off = i_req.addr - i_win_base;
   assign map_off = i_req.addr - i_map_base;
   assign win_hit = (win_off[31:pvat_pkg::WIN_SHIFT] == '0);
   assign map_hit = (map_off[31:pvat_pkg::MAP_SHIFT] == '0);
   assign map_entry_hit = map_hit && (map_off <= pvat_pkg::MAP_ENTRY_LAST) &&
                          (map_off >= pvat_pkg::MAP_ENTRY_FIRST);
   assign o_req_ready = (state_reg == PVAT_ST_IDLE);
   assign take = i_req_valid && o_req_ready && (win_hit || map_hit);
   // Window offset / 4096 picks the page entry; map offset / 4 picks the register
   assign rd_index = map_hit ? map_off[14:2] : win_off[24:pvat_pkg::PAGE_SHIFT];
   // Byte writes are dropped; a word write lands in one half only
   assign tbl_wr_en = take && map_entry_hit && i_req.write && (i_req.size != pvat_pkg::PVAT_SZ_BYTE);
   assign tbl_wr_half = (i_req.size == pvat_pkg::PVAT_SZ_LONG) ? 2'b11 :
                        (i_req.addr[1] ? 2'b10 : 2'b01);

   pvat_entry_table u_table (
      .i_ref_clk(i_ref_clk),
      .i_wr_en(tbl_wr_en),
      .i_wr_index(rd_index),
      .i_wr_half(tbl_wr_half),
      .i_wr_data(i_req.wdata),
      .i_rd_index(rd_index),
      .o_rd_data(entry)
   );

   assign local_dpr_req = ((state_reg == PVAT_ST_SEND) || (state_reg == PVAT_ST_WAIT)) &&
                          (rem_reg.dest == pvat_pkg::PVAT_DEST_DPR);

   pvat_dpr_arbiter u_arb (
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .i_req({i_far_dpr_req, local_dpr_req}),
      .o_gnt(dpr_gnt)
   );

   assign o_far_dpr_gnt = dpr_gnt[1];
   // A dual port RAM cycle waits for the local grant; other destinations go at once
   assign send_ok = (rem_reg.dest != pvat_pkg::PVAT_DEST_DPR) || dpr_gnt[0];

   // Translation of the held request through the entry just read
   always_comb begin
      xl = '0;
      xl.addr = {entry[31:pvat_pkg::RADDR_LSB], req_reg.addr[11:0]};
      xl.dest = pvat_pkg::pvat_dest_type'(entry[pvat_pkg::DEST_LSB +: 2]);
      xl.am = entry[pvat_pkg::AM_LSB +: 6];
      xl.swap_wide = entry[pvat_pkg::BIT_SWAP_WIDE];
      xl.swap_word = entry[pvat_pkg::BIT_SWAP_WORD];
      xl.swap_byte = entry[pvat_pkg::BIT_SWAP_BYTE];
      xl.write = req_reg.write;
      xl.size = req_reg.size;
      if (xl.dest == pvat_pkg::PVAT_DEST_DPR) begin
         xl.am = '0;
      end else if (xl.am == pvat_pkg::AM_A16_SUP || xl.am == pvat_pkg::AM_A16_USR ||
                   xl.am == pvat_pkg::AM_A16_LCK) begin
         xl.addr[31:16] = '0;
      end
      if (req_reg.size == pvat_pkg::PVAT_SZ_WORD && xl.swap_word) begin
         xl.addr[1] = ~xl.addr[1];
      end
      if (req_reg.size == pvat_pkg::PVAT_SZ_BYTE && xl.swap_byte) begin
         xl.addr[0] = ~xl.addr[0];
      end
      xl.wdata = swap_lanes(req_reg.size, xl.swap_wide, xl.swap_word, xl.swap_byte, req_reg.wdata);
   end

   always_comb begin
      state_next = state_reg;
      req_next = req_reg;
      kind_map_next = kind_map_reg;
      map_low_next = map_low_reg;
      rem_next = rem_reg;
      rsp_data_next = rsp_data_reg;
      rsp_valid_next = 1'b0;
      invalid_next = 1'b0;
      look_index_next = take ? rd_index : look_index_reg;
      unique case (state_reg)
         PVAT_ST_IDLE: begin
            if (take) begin
               req_next = i_req;
               kind_map_next = map_hit;
               map_low_next = map_entry_hit;
               state_next = PVAT_ST_LOOK;
            end
         end
         PVAT_ST_LOOK: begin
            if (kind_map_reg) begin
               // Other sections of the mapping window read as zero here
               rsp_data_next = map_low_reg ? entry : '0;
               rsp_valid_next = 1'b1;
               state_next = PVAT_ST_IDLE;
            end else if (entry[pvat_pkg::BIT_INVALID]) begin
               // No answer is given, so the master's own timeout ends the cycle
               invalid_next = 1'b1;
               state_next = PVAT_ST_IDLE;
            end else begin
               rem_next = xl;
               state_next = PVAT_ST_SEND;
            end
         end
         PVAT_ST_SEND: begin
            if (send_ok && i_rem_ready) begin
               state_next = PVAT_ST_WAIT;
            end
         end
         PVAT_ST_WAIT: begin
            if (i_rem_rsp_valid) begin
               rsp_data_next = swap_lanes(rem_reg.size, rem_reg.swap_wide, rem_reg.swap_word,
                                          rem_reg.swap_byte, i_rem_rsp_rdata);
               rsp_valid_next = 1'b1;
               state_next = PVAT_ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         state_reg <= PVAT_ST_IDLE;
         req_reg <= '0;
         kind_map_reg <= 1'b0;
         map_low_reg <= 1'b0;
         rem_reg <= '0;
         rsp_data_reg <= '0;
         rsp_valid_reg <= 1'b0;
         invalid_reg <= 1'b0;
         look_index_reg <= '0;
      end else begin
         state_reg <= state_next;
         req_reg <= req_next;
         kind_map_reg <= kind_map_next;
         map_low_reg <= map_low_next;
         rem_reg <= rem_next;
         rsp_data_reg <= rsp_data_next;
         rsp_valid_reg <= rsp_valid_next;
         invalid_reg <= invalid_next;
         look_index_reg <= look_index_next;
      end
   end

   assign o_rsp_valid = rsp_valid_reg;
   assign o_rsp_rdata = rsp_data_reg;
   assign o_page_invalid = invalid_reg;
   assign o_rem_valid = (state_reg == PVAT_ST_SEND) && send_ok;
   assign o_rem = rem_reg;

   // Checks on the lookup index, the outbound request, the answers and the shared RAM grant

   a_index_select: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (take && !map_hit) |=> (look_index_reg == $past(win_off[24:12])))
      else $error("page index not taken from window offset");
   a_addr_concat: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      o_rem_valid |-> (o_rem.addr[11:2] == req_reg.addr[11:2]))
      else $error("page offset bits not carried through");
   a_invalid_block: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (state_reg == PVAT_ST_LOOK && !kind_map_reg && entry[0]) |=> (!o_rem_valid && o_page_invalid) ##1 !o_rem_valid)
      else $error("invalid page produced a remote cycle");
   a_dpr_no_am: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (o_rem_valid && o_rem.dest == pvat_pkg::PVAT_DEST_DPR) |-> (o_rem.am == 6'h00))
      else $error("dual port RAM access carried a modifier");
   a_size_keep: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      o_rem_valid |-> (o_rem.size == req_reg.size && o_rem.write == req_reg.write))
      else $error("size or direction changed");
   a_a1_invert: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (o_rem_valid && o_rem.size == pvat_pkg::PVAT_SZ_WORD) |->
      (o_rem.addr[1] == (req_reg.addr[1] ^ o_rem.swap_word)))
      else $error("A1 not inverted as the entry asks");
   a_byte_swap: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (o_rem_valid && o_rem.size == pvat_pkg::PVAT_SZ_BYTE) |->
      (o_rem.addr[0] == (req_reg.addr[0] ^ o_rem.swap_byte)))
      else $error("byte swap not applied to byte transfer");
   a_long_swap: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (o_rem_valid && o_rem.size == pvat_pkg::PVAT_SZ_LONG && o_rem.swap_wide) |->
      (o_rem.wdata == {req_reg.wdata[7:0], req_reg.wdata[15:8], req_reg.wdata[23:16], req_reg.wdata[31:24]}))
      else $error("longword bytes not reversed");
   a_dpr_excl: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (o_rem_valid && o_rem.dest == pvat_pkg::PVAT_DEST_DPR) |-> !o_far_dpr_gnt)
      else $error("both sides granted the dual port RAM");
   a_reg_answer: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (take && map_hit) |=> ##1 o_rsp_valid)
      else $error("mapping register access not answered in two cycles");
   a_rem_hold: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (o_rem_valid && !i_rem_ready) |=> (o_rem_valid && $stable(o_rem)))
      else $error("remote request changed before acceptance");
   a_rem_once: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (o_rem_valid && i_rem_ready) |=> !o_rem_valid)
      else $error("remote request sent twice");
   a_map_zero: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (state_reg == PVAT_ST_LOOK && kind_map_reg && !map_low_reg) |=> (o_rsp_valid && o_rsp_rdata == 32'h0000_0000))
      else $error("read outside the entry range not zero");
   a_a16_upper: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (o_rem_valid && (o_rem.am == pvat_pkg::AM_A16_SUP || o_rem.am == pvat_pkg::AM_A16_USR ||
      o_rem.am == pvat_pkg::AM_A16_LCK)) |-> (o_rem.addr[31:16] == 16'h0000))
      else $error("short address space carried upper bits");
   a_far_held: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (o_far_dpr_gnt && i_far_dpr_req) |=> o_far_dpr_gnt)
      else $error("far grant dropped while still requested");
endmodule
`default_nettype wire

// [pvat_remote_model.sv]
// Far-end adapter card model: accepts remote requests and answers after a delay
`timescale 1ns/1ps
`default_nettype none
module pvat_remote_model (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic i_slow,
   input wire logic i_rem_valid,
   input wire pvat_pkg::pvat_rem_type i_rem,
   output logic o_rem_ready,
   output logic o_rsp_valid,
   output logic [31:0] o_rsp_rdata,
   output pvat_pkg::pvat_rem_type o_seen
);
   localparam logic [31:0] READ_WORD = 32'hA1B2_C3D4;
   logic [2:0] wait_reg;
   logic [2:0] rsp_reg;
   always_ff @(posedge i_ref_clk) begin
      // Idle read lines carry the inverse so stale data cannot pass for an answer
      o_rsp_rdata <= ~READ_WORD;
      o_rsp_valid <= 1'b0;
      if (i_reset) begin
         o_rem_ready <= 1'b0;
         wait_reg <= 3'h0;
         rsp_reg <= 3'h0;
         o_seen <= '0;
      end else begin
         if (i_rem_valid && o_rem_ready) begin
            o_seen <= i_rem;
            o_rem_ready <= 1'b0;
            wait_reg <= 3'h0;
            rsp_reg <= i_slow ? 3'h5 : 3'h1;
         end else if (i_rem_valid) begin
            wait_reg <= wait_reg + 3'h1;
            o_rem_ready <= !i_slow || wait_reg == 3'h3;
         end
         if (rsp_reg == 3'h1) begin
            o_rsp_valid <= 1'b1;
            o_rsp_rdata <= READ_WORD;
         end
         if (rsp_reg != 3'h0)
            rsp_reg <= rsp_reg - 3'h1;
      end
   end
endmodule
`default_nettype wire

// [pvat_translator_tb.sv]
// Self-checking bench for the remote window translator
`timescale 1ns/1ps
`default_nettype none
module pvat_translator_tb;
   localparam logic [31:0] WIN = 32'h8000_0000;
   localparam logic [31:0] MAP = 32'h8200_0000;
   logic clk;
   logic rst;
   logic req_valid;
   logic req_ready;
   pvat_pkg::pvat_req_type req;
   logic rsp_valid;
   logic [31:0] rsp_rdata;
   logic page_inv;
   logic rem_valid;
   logic rem_ready;
   pvat_pkg::pvat_rem_type rem;
   pvat_pkg::pvat_rem_type seen;
   logic rr_valid;
   logic [31:0] rr_data;
   logic far_req;
   logic far_gnt;
   logic slow;
   logic inv;
   int n_mismatch = 0;
   int n_checks = 0;
   int n_rem = 0;

   pvat_translator u_dut (
      .i_ref_clk(clk), .i_reset(rst), .i_win_base(WIN), .i_map_base(MAP),
      .i_req_valid(req_valid), .o_req_ready(req_ready), .i_req(req),
      .o_rsp_valid(rsp_valid), .o_rsp_rdata(rsp_rdata), .o_page_invalid(page_inv),
      .o_rem_valid(rem_valid), .i_rem_ready(rem_ready), .o_rem(rem),
      .i_rem_rsp_valid(rr_valid), .i_rem_rsp_rdata(rr_data),
      .i_far_dpr_req(far_req), .o_far_dpr_gnt(far_gnt)
   );
   pvat_remote_model u_far (
      .i_ref_clk(clk), .i_reset(rst), .i_slow(slow), .i_rem_valid(rem_valid),
      .i_rem(rem), .o_rem_ready(rem_ready), .o_rsp_valid(rr_valid),
      .o_rsp_rdata(rr_data), .o_seen(seen)
   );

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk)
      if (rem_valid && rem_ready)
         n_rem <= n_rem + 1;

   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Called at a falling edge with the block idle; returns once it has answered, flagged an invalid page or waited 40 cycles
   task automatic acc(input logic [31:0] a, input logic w, input logic [1:0] sz, input logic [31:0] d);
      int k;
      req = '{addr: a, write: w, size: pvat_pkg::pvat_size_type'(sz), wdata: d};
      req_valid = 1'b1;
      @(posedge clk);
      @(negedge clk);
      req_valid = 1'b0;
      for (k = 0; k < 40 && !rsp_valid && !page_inv; k++)
         @(negedge clk);
      inv = page_inv;
      if (k == 40)
         chk("answer", 32'h1, 32'h0);
   endtask

   task automatic wr(input int n, input logic [31:0] v);
      acc(MAP + 32'(n) * 32'h4, 1'b1, 2'h2, v);
   endtask

   task automatic rd(input int n, input logic [31:0] exp);
      acc(MAP + 32'(n) * 32'h4, 1'b0, 2'h2, 32'h0);
      chk("entry", exp, rsp_rdata);
   endtask

   task automatic pg(input int p, input logic [11:0] off, input logic w, input logic [1:0] sz, input logic [31:0] d);
      acc(WIN + 32'(p) * 32'h1000 + {20'h0_0000, off}, w, sz, d);
   endtask

   task automatic t_table;
      wr(0, 32'h1234_5678);
      wr(8191, 32'hCAFE_0001);
      rd(0, 32'h1234_5678);
      rd(8191, 32'hCAFE_0001);
      acc(MAP + 32'h2, 1'b1, 2'h1, 32'h5A5A_0000);
      acc(MAP + 32'h1, 1'b1, 2'h0, 32'hFFFF_FFFF);
      rd(0, 32'h5A5A_5678);
      acc(MAP + 32'h8000, 1'b0, 2'h2, 32'h0);
      chk("unmapped", 32'h0, rsp_rdata);
   endtask

   // Reserved destination is never programmed, so the loop starts at 1
   task automatic t_xlate;
      int p;
      for (int c = 1; c < 4; c++) begin
         p = (c == 3) ? 8191 : c * 2731;
         wr(p, {16'h1234, 4'(c), 6'h0D, 2'(c), 4'h0});
         pg(p, 12'h024, c[0], 2'(c % 3), 32'h0102_0304);
         chk("addr", {16'h1234, 4'(c), 12'h024}, seen.addr);
         chk("am", (c == 3) ? 32'h0 : 32'h0D, 32'(seen.am));
         chk("dest", 32'(c), 32'(seen.dest));
         chk("size", 32'(c % 3), 32'(seen.size));
         chk("write", 32'(c % 2), 32'(seen.write));
         if (c == 2)
            chk("rdata", 32'hA1B2_C3D4, rsp_rdata);
      end
   endtask

   task automatic t_invalid;
      int n;
      wr(9, {20'h0_0001, 6'h0D, 2'h2, 4'h1});
      n = n_rem;
      pg(9, 12'h000, 1'b0, 2'h2, 32'h0);
      chk("invalid", 32'h1, 32'(inv));
      chk("no remote", 32'(n), 32'(n_rem));
      wr(9, {20'h0_0001, 6'h0D, 2'h2, 4'h0});
      pg(9, 12'h000, 1'b0, 2'h2, 32'h0);
      chk("valid", 32'h0, 32'(inv));
   endtask

   task automatic sw(input logic [3:0] fl, input logic [1:0] sz, input logic [31:0] d, input logic [11:0] ea,
                     input logic [31:0] ed);
      wr(10, {20'h0_0ABC, 6'h0D, 2'h2, fl});
      pg(10, 12'h010, 1'b1, sz, d);
      chk("swap addr", {20'h0_0ABC, ea}, seen.addr);
      chk("swap data", ed, seen.wdata);
      chk("swap bits", 32'(fl[3:1]), 32'({seen.swap_byte, seen.swap_word, seen.swap_wide}));
   endtask

   // Slow far end here so the held request is seen across several cycles
   task automatic t_swap;
      slow = 1'b1;
      sw(4'h2, 2'h2, 32'h1122_3344, 12'h010, 32'h4433_2211);
      pg(10, 12'h010, 1'b0, 2'h2, 32'h0);
      chk("swap rdata", 32'hD4C3_B2A1, rsp_rdata);
      sw(4'h2, 2'h0, 32'h0000_0077, 12'h010, 32'h0000_0077);
      sw(4'h2, 2'h1, 32'h0000_1234, 12'h010, 32'h0000_3412);
      sw(4'h4, 2'h1, 32'h0000_BEEF, 12'h012, 32'hBEEF_0000);
      sw(4'h8, 2'h0, 32'h0000_0077, 12'h011, 32'h0000_7700);
      slow = 1'b0;
   endtask

   task automatic t_a16;
      wr(11, {20'hF_FFF1, 6'h29, 2'h1, 4'h0});
      pg(11, 12'h246, 1'b0, 2'h1, 32'h0);
      chk("a16 addr", 32'h0000_1246, seen.addr);
   endtask

   task automatic t_dpr;
      logic held;
      held = 1'b0;
      wr(12, {20'h0_0000, 6'h3F, 2'h3, 4'h0});
      far_req = 1'b1;
      repeat (3) @(negedge clk);
      chk("far grant", 32'h1, 32'(far_gnt));
      fork
         pg(12, 12'h008, 1'b1, 2'h2, 32'h5555_AAAA);
         begin
            repeat (8) begin
               @(negedge clk);
               held = held | rem_valid;
            end
            far_req = 1'b0;
         end
      join
      chk("dpr wait", 32'h0, 32'(held));
      chk("dpr addr", 32'h0000_0008, seen.addr);
      chk("dpr am", 32'h0, 32'(seen.am));
      chk("far release", 32'h0, 32'(far_gnt));
   endtask

   // Reset lands while a slow remote cycle is outstanding; the block must come back idle
   task automatic t_reset;
      slow = 1'b1;
      req = '{addr: WIN + 32'h0000_A010, write: 1'b0, size: pvat_pkg::PVAT_SZ_LONG, wdata: 32'h0000_0000};
      req_valid = 1'b1;
      @(negedge clk);
      req_valid = 1'b0;
      chk("busy ready", 32'h0, 32'(req_ready));
      @(negedge clk);
      chk("pending", 32'h1, 32'(rem_valid));
      rst = 1'b1;
      @(negedge clk);
      rst = 1'b0;
      chk("reset ready", 32'h1, 32'(req_ready));
      chk("reset rem", 32'h0, 32'(rem_valid));
      chk("reset pulses", 32'h0, 32'({rsp_valid, page_inv, far_gnt}));
      chk("reset addr", 32'h0, rem.addr);
      slow = 1'b0;
      pg(10, 12'h010, 1'b0, 2'h2, 32'h0);
      chk("after reset", 32'hA1B2_C3D4, rsp_rdata);
   endtask

   initial begin
      rst = 1'b1;
      req_valid = 1'b0;
      req = '0;
      far_req = 1'b0;
      slow = 1'b0;
      inv = 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      t_table();
      t_xlate();
      t_invalid();
      t_swap();
      t_a16();
      t_dpr();
      t_reset();
      stop_test();
   end

   initial begin
      #100000;
      n_mismatch++;
      stop_test();
   end
endmodule
`default_nettype wire
